// ---- core/iect_timer.sv ----
// Top: 16-bit interval timer / external event counter channel
// Function
// RULE1: Mode 000 with enable raises match_irq_zero every programmed interval.
// RULE2: On enable the counter goes FFFFH to 0000H on a count clock.
// RULE3: Interval mode toggles primary output when counting starts.
// RULE4: Count start copies compare value zero into compare buffer zero.
// RULE5: Match on buffer zero clears counter, toggles primary output, raises irq.
// RULE6: Interval period is compare value zero plus one count clocks.
// RULE7: Compare zero at 0000H gives irq and toggle every count clock.
// RULE8: Compare FFFFH wraps to zero with match irq, no overflow flag.
// RULE9: Compare zero writes reach buffer at once; overshoot wraps through FFFFH.
// RULE10: Software should stop counting before lowering compare value zero.
// RULE11: Compare one below compare zero raises irq one and toggles secondary.
// RULE12: Compare one above compare zero never matches; secondary output unchanged.
// RULE13: Mode 001 counts external edges; primary output unused.
// RULE14: Event mode clears counter and raises irq after compare plus one edges.
// RULE15: Event mode still loads buffer one and raises its match irq.
// RULE16: Reading the counter read buffer returns the live counter.
// RULE17: External clock enters only on capture pin with edge select 00; the code takes pin edges whatever the edge select field holds.
// RULE18: Event mode ignores the I/O control and option registers.
// RULE19: Mode 000 with external select counts pin edges, outputs usable.
// RULE20: Clearing enable stops; setting again restarts and reloads buffers.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module iect_timer #(
  parameter logic [7:0] count_div = 8'h00
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic capture_trigger_input,
  output logic primary_timer_output,
  output logic secondary_timer_output,
  output logic match_irq_zero,
  output logic match_irq_one,
  output logic overflow_irq
);
  typedef enum logic [1:0] {
    iect_idle = 2'b00,
    iect_arm = 2'b01,
    iect_run = 2'b11
  } iect_phase_t;

  typedef struct packed {
    iect_phase_t phase;
    logic [7:0] timer_control_reg0;
    logic [7:0] timer_control_reg1;
    logic [7:0] io_control_reg1;
    logic [7:0] option_register;
    logic [15:0] compare_value_zero;
    logic [15:0] compare_value_one;
    logic [15:0] compare_buffer_zero;
    logic [15:0] compare_buffer_one;
    logic [15:0] count;
    logic primary;
    logic secondary;
    logic irq0;
    logic irq1;
    logic [15:0] rdata;
  } iect_state_t;

  iect_state_t st;
  iect_state_t next_st;

  logic count_enable_bit;
  logic [2:0] mode_sel;
  logic external_event_select_bit;
  logic [1:0] capture_edge_sel;
  logic ext_clk;
  logic int_tick;
  logic tick;
  logic is_interval;
  logic is_event;
  logic counting;
  logic match0;
  logic match1;
  logic [15:0] rd_mux;

  iect_edge_if edge_if ();

  // Decode of control fields
  assign count_enable_bit = st.timer_control_reg0[iect_pkg::ce_bit];
  assign mode_sel = st.timer_control_reg1[iect_pkg::md_lsb +: iect_pkg::md_w];
  assign external_event_select_bit = st.timer_control_reg1[iect_pkg::eee_bit];
  assign capture_edge_sel = st.io_control_reg1[iect_pkg::is_lsb +: 2];
  assign is_interval = (mode_sel == iect_pkg::mode_interval);
  assign is_event = (mode_sel == iect_pkg::mode_event);
  assign counting = count_enable_bit & (is_interval | is_event);
  // Pin clock only when event mode or external select; mode 001 ignores IOC1/OPT0
  assign ext_clk = is_event | (is_interval & external_event_select_bit); // RULE13 RULE17 RULE18 RULE19

  // Pin edges feed the count only when chosen as count clock
  assign edge_if.enable = counting & ext_clk; // RULE17

  iect_edge u_edge (
    .core_clk(core_clk),
    .rstn(rstn),
    .pin(capture_trigger_input),
    .edge_if(edge_if)
  );

  iect_cdiv #(
    .div(count_div)
  ) u_cdiv (
    .core_clk(core_clk),
    .rstn(rstn),
    .run(counting & ~ext_clk),
    .tick(int_tick)
  );

  // One count clock source at a time
  assign tick = ext_clk ? edge_if.pulse : int_tick; // RULE13 RULE19

  // Compare against buffers, not the registers
  assign match0 = (st.count == st.compare_buffer_zero); // RULE5 RULE6
  assign match1 = (st.count == st.compare_buffer_one); // RULE11 RULE12 RULE15

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_mux = iect_pkg::word_zero;
    unique case (reg_addr)
      iect_pkg::off_ctl0: rd_mux = {8'h00, st.timer_control_reg0};
      iect_pkg::off_ctl1: rd_mux = {8'h00, st.timer_control_reg1};
      iect_pkg::off_ioc1: rd_mux = {8'h00, st.io_control_reg1};
      iect_pkg::off_opt0: rd_mux = {8'h00, st.option_register};
      iect_pkg::off_ccr0: rd_mux = st.compare_value_zero;
      iect_pkg::off_ccr1: rd_mux = st.compare_value_one;
      iect_pkg::off_cnt: rd_mux = st.count; // RULE16
      iect_pkg::off_out: rd_mux = {14'h0000, st.secondary, st.primary};
      default: rd_mux = iect_pkg::word_zero;
    endcase
  end

  // Next state: register writes, start sequence, counting
  always_comb begin
    next_st = st;
    next_st.irq0 = 1'b0;
    next_st.irq1 = 1'b0;
    next_st.rdata = reg_rd ? rd_mux : iect_pkg::word_zero;
    if (reg_wr) begin
      unique case (reg_addr)
        iect_pkg::off_ctl0: next_st.timer_control_reg0 = reg_wdata[7:0];
        iect_pkg::off_ctl1: next_st.timer_control_reg1 = reg_wdata[7:0];
        iect_pkg::off_ioc1: next_st.io_control_reg1 = reg_wdata[7:0];
        iect_pkg::off_opt0: next_st.option_register = reg_wdata[7:0];
        iect_pkg::off_ccr0: next_st.compare_value_zero = reg_wdata;
        iect_pkg::off_ccr1: next_st.compare_value_one = reg_wdata;
        default: next_st.rdata = next_st.rdata;
      endcase
    end
    unique case (st.phase)
      iect_idle: begin
        // Stopped counter rests at FFFFH for the next start
        next_st.count = iect_pkg::cnt_top; // RULE20
        if (counting) begin
          next_st.phase = iect_arm;
        end
      end
      iect_arm: begin
        if (!counting) begin
          next_st.phase = iect_idle; // RULE20
        end else if (tick) begin
          next_st.phase = iect_run;
          next_st.count = iect_pkg::cnt_zero; // RULE2
          next_st.compare_buffer_zero = st.compare_value_zero; // RULE4 RULE20
          next_st.compare_buffer_one = st.compare_value_one; // RULE15 RULE20
          if (is_interval) begin
            next_st.primary = ~st.primary; // RULE3
          end
        end
      end
      iect_run: begin
        // Compare registers are anytime write: buffers follow at once
        next_st.compare_buffer_zero = st.compare_value_zero; // RULE9
        next_st.compare_buffer_one = st.compare_value_one;
        if (!counting) begin
          // Counter reads FFFFH from the edge after the stop, not one edge later
          next_st.phase = iect_idle; // RULE20
          next_st.count = iect_pkg::cnt_top; // RULE20
        end else if (tick) begin
          if (match0) begin
            // Clear on match; FFFFH match wraps with no overflow event
            next_st.count = iect_pkg::cnt_zero; // RULE5 RULE7 RULE8 RULE14
            next_st.irq0 = 1'b1; // RULE1 RULE14
            if (is_interval) begin
              next_st.primary = ~st.primary; // RULE5 RULE7
            end
          end else begin
            // Overshoot past a lowered compare wraps naturally
            next_st.count = st.count + iect_pkg::cnt_one; // RULE9
          end
          if (match1) begin
            next_st.irq1 = 1'b1; // RULE11 RULE15
            if (is_interval) begin
              next_st.secondary = ~st.secondary; // RULE11 RULE12
            end
          end
        end
      end
      default: next_st.phase = iect_idle;
    endcase
  end

  // Registered state
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st <= '0;
      st.count <= iect_pkg::cnt_top;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign primary_timer_output = st.primary;
  assign secondary_timer_output = st.secondary;
  assign match_irq_zero = st.irq0;
  assign match_irq_one = st.irq1;
  // Overflow is never raised in these two modes
  assign overflow_irq = 1'b0; // RULE8
endmodule

// ---- core/iect_pkg.sv ----
// Package: register map, field layout and constants of the interval/event timer
package iect_pkg;
  localparam int unsigned addr_w = 4;
  localparam logic [3:0] off_ctl0 = 4'h0;
  localparam logic [3:0] off_ctl1 = 4'h1;
  localparam logic [3:0] off_ioc1 = 4'h2;
  localparam logic [3:0] off_opt0 = 4'h3;
  localparam logic [3:0] off_ccr0 = 4'h4;
  localparam logic [3:0] off_ccr1 = 4'h5;
  localparam logic [3:0] off_cnt = 4'h6;
  localparam logic [3:0] off_out = 4'h7;
  // Control register 0 field
  localparam int unsigned ce_bit = 7;
  // Control register 1 fields
  localparam int unsigned eee_bit = 5;
  localparam int unsigned md_lsb = 0;
  localparam int unsigned md_w = 3;
  localparam logic [2:0] mode_interval = 3'h0;
  localparam logic [2:0] mode_event = 3'h1;
  // I/O control register 1 capture edge field
  localparam int unsigned is_lsb = 0;
  localparam logic [1:0] is_none = 2'h0;
  localparam logic [15:0] cnt_top = 16'hffff;
  localparam logic [15:0] cnt_zero = 16'h0000;
  localparam logic [15:0] cnt_one = 16'h0001;
  localparam logic [7:0] byte_zero = 8'h00;
  localparam logic [15:0] word_zero = 16'h0000;
endpackage

// ---- core/iect_edge_if.sv ----
// Interface: event edge detector to timer core
`timescale 1ns/1ps
interface iect_edge_if;
  logic pulse;
  logic enable;
  modport src (output pulse, input enable);
  modport dst (input pulse, output enable);
endinterface

// ---- core/iect_edge.sv ----
// Synchroniser and rising edge detector for the capture trigger pin
`timescale 1ns/1ps
module iect_edge (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic pin,
  iect_edge_if.src edge_if
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } iect_edge_state_t;
  iect_edge_state_t st;
  iect_edge_state_t next_st;

  // Edge seen only from the second stage onward
  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  // Registered state
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Rising edge is the valid event edge
  assign edge_if.pulse = edge_if.enable & st.s2 & ~st.s3;
endmodule

// ---- core/iect_cdiv.sv ----
// Count clock enable divider for the internal count clock
`timescale 1ns/1ps
module iect_cdiv #(
  parameter logic [7:0] div = 8'h00
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic run,
  output logic tick
);
  typedef struct packed {
    logic [7:0] cnt;
  } iect_cdiv_state_t;
  iect_cdiv_state_t st;
  iect_cdiv_state_t next_st;

  // Restart phase whenever counting stops
  always_comb begin
    next_st = st;
    if (!run || st.cnt == div) begin
      next_st.cnt = iect_pkg::byte_zero;
    end else begin
      next_st.cnt = st.cnt + 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = run & (st.cnt == div);
endmodule

// ---- dv/iect_timer_asserts.sv ----
// Checker: port-level timing of the interval and event timer channel
`timescale 1ns/1ps
module iect_timer_asserts #(
  parameter logic [7:0] count_div = 8'h00
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic capture_trigger_input,
  input wire logic primary_timer_output,
  input wire logic secondary_timer_output,
  input wire logic match_irq_zero,
  input wire logic match_irq_one,
  input wire logic overflow_irq
);
  logic [2:0] mode;
  // Mode shadowed from bus writes, since the ports do not show it
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mode <= 3'h0;
    end else if (reg_wr && reg_addr == iect_pkg::off_ctl1) begin
      mode <= reg_wdata[2:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_one_pulse;
    match_irq_one ##1 !match_irq_one;
  endsequence
  a_no_overflow: assert property (!overflow_irq)
    else $error("overflow request raised");
  a_irq0_pulse: assert property (match_irq_zero && count_div != 8'h00 |=> !match_irq_zero)
    else $error("zero match request longer than one cycle");
  a_irq1_pulse: assert property ($rose(match_irq_one) && count_div != 8'h00 |-> s_one_pulse)
    else $error("one match request longer than one cycle");
  a_prim_match: assert property (match_irq_zero && mode == iect_pkg::mode_interval
    |-> primary_timer_output != $past(primary_timer_output))
    else $error("primary output did not toggle on zero match");
  a_sec_match: assert property (match_irq_one && mode == iect_pkg::mode_interval
    |-> secondary_timer_output != $past(secondary_timer_output))
    else $error("secondary output did not toggle on one match");
  a_sec_cause: assert property ($changed(secondary_timer_output) |-> match_irq_one)
    else $error("secondary output moved without a match");
  a_event_quiet: assert property (mode == iect_pkg::mode_event
    && $past(mode) == iect_pkg::mode_event |-> $stable(primary_timer_output))
    else $error("primary output moved in event mode");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == iect_pkg::word_zero)
    else $error("read data not zero outside answer cycle");
  a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > 4'h7
    |-> reg_rdata == 16'h0000)
    else $error("unmapped read returned data");
endmodule

// ---- dv/iect_pin_src.sv ----
// Partner model: external event source on the capture trigger pin
`timescale 1ns/1ps
module iect_pin_src (
  input wire logic core_clk,
  output logic pin
);
  initial pin = 1'b0;
  // Pulses held for gap cycles so they survive the synchroniser
  task automatic send(input int n, input int gap);
    repeat (n) begin
      @(posedge core_clk);
      pin <= 1'b1;
      repeat (gap) @(posedge core_clk);
      pin <= 1'b0;
      repeat (gap) @(posedge core_clk);
    end
  endtask
endmodule

// ---- dv/iect_timer_tb.sv ----
// Testbench: register, interval and event scenarios for the timer channel
`timescale 1ns/1ps
module iect_timer_tb;
  localparam int tk = 2; // Cycles per count clock with a divider of one
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic pin, prim, sec, irq0, irq1, p0, s0;
  logic [15:0] rv;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0, n0 = 0, n1 = 0, last0 = 0, gap0 = 0, k, k1;
  iect_timer #(.count_div(8'h01)) u_dut (.core_clk(core_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .capture_trigger_input(pin), .primary_timer_output(prim),
    .secondary_timer_output(sec), .match_irq_zero(irq0), .match_irq_one(irq1),
    .overflow_irq());
  iect_pin_src u_src (.core_clk(core_clk), .pin(pin));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // Match pulse counts and spacing
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (irq0 === 1'b1) begin
      n0 <= n0 + 1;
      gap0 <= cyc - last0;
      last0 <= cyc;
    end
    if (irq1 === 1'b1) n1 <= n1 + 1;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Idle edge after each strobe so no signal is set twice in one step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
    @(posedge core_clk);
  endtask
  task automatic upto(input int m);
    for (int i = 0; i < 3000 && n0 < m; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (n0 < m) chk("zero match wait", 16'h0001, 16'h0000);
  endtask
  task automatic t_regs;
    rd(iect_pkg::off_ccr0, 16'h0000, "ccr0 reset");
    wr(iect_pkg::off_ccr1, 16'h5a3c);
    rd(iect_pkg::off_ccr1, 16'h5a3c, "ccr1");
    wr(iect_pkg::off_cnt, 16'h1234);
    rd(iect_pkg::off_cnt, 16'hffff, "idle counter");
    rd(4'hc, 16'h0000, "unmapped");
  endtask
  task automatic t_interval;
    wr(iect_pkg::off_ccr0, 16'h0003);
    wr(iect_pkg::off_ccr1, 16'h0001);
    wr(iect_pkg::off_ctl1, 16'h0000);
    p0 = prim;
    wr(iect_pkg::off_ctl0, 16'h0080);
    repeat (4) @(posedge core_clk);
    #1;
    chk("start toggle", 16'(!p0), 16'(prim));
    upto(n0 + 2);
    chk("interval", 16'(4 * tk), 16'(gap0));
    s0 = sec;
    k1 = n1;
    upto(n0 + 1);
    chk("secondary toggle", 16'(!s0), 16'(sec));
    chk("one match per cycle", 16'h0001, 16'(n1 - k1));
    wr(iect_pkg::off_ccr1, 16'h0009);
    s0 = sec;
    k1 = n1;
    upto(n0 + 3);
    chk("no one match", 16'(k1), 16'(n1));
    chk("secondary held", 16'(s0), 16'(sec));
    wr(iect_pkg::off_ctl0, 16'h0000);
    rd(iect_pkg::off_cnt, 16'hffff, "stopped counter");
  endtask
  task automatic t_zero;
    wr(iect_pkg::off_ccr0, 16'h0000);
    wr(iect_pkg::off_ctl0, 16'h0080);
    upto(n0 + 3);
    chk("zero compare spacing", 16'(tk), 16'(gap0));
    wr(iect_pkg::off_ctl0, 16'h0000);
  endtask
  task automatic t_edges(input logic [15:0] c1, input logic tog);
    wr(iect_pkg::off_ioc1, 16'h0000);
    wr(iect_pkg::off_opt0, 16'h00ff);
    wr(iect_pkg::off_ctl1, c1);
    wr(iect_pkg::off_ccr0, 16'h0002);
    wr(iect_pkg::off_ccr1, 16'h0001);
    wr(iect_pkg::off_ctl0, 16'h0080);
    k = n0;
    for (int i = 0; i < 6 && n0 == k; i++) begin
      u_src.send(1, 4);
      #1;
    end
    rd(iect_pkg::off_cnt, 16'h0000, "cleared counter");
    k = n0;
    k1 = n1;
    u_src.send(2, 4);
    rd(iect_pkg::off_cnt, 16'h0002, "edge count");
    p0 = prim;
    u_src.send(1, 4);
    #1;
    chk("edge match", 16'(k + 1), 16'(n0));
    chk("edge one match", 16'(k1 + 1), 16'(n1));
    chk("primary", 16'(p0 ^ tog), 16'(prim));
    wr(iect_pkg::off_ctl0, 16'h0000);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    t_regs;
    t_interval;
    t_zero;
    t_edges(16'h0001, 1'b0);
    t_edges(16'h0020, 1'b1);
    test_done;
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    test_done;
  end
endmodule
bind iect_timer iect_timer_asserts #(.count_div(count_div)) u_chk (.core_clk(core_clk),
  .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .capture_trigger_input(capture_trigger_input),
  .primary_timer_output(primary_timer_output),
  .secondary_timer_output(secondary_timer_output), .match_irq_zero(match_irq_zero),
  .match_irq_one(match_irq_one), .overflow_irq(overflow_irq));
